// *** logic/ss_abort_regs.svh ***
/*
 Register offsets, field positions, reset values and timing counts for the
 spread-spectrum and abort control block. Assumes the including file is compiled
 after the package ss_abort_pkg.
*/
// Behaviour
// - Length code selects register length and taps.
// - Sequence output randomizes spread bit frequency.
// - Swing code 10 enables pseudo-random deviation.
// - Swing code 11 disables deviation, offset still trims.
// - Fast acquisition 64 cycles after reset or offset write.
// - Nine-bit offset, zero gives minimum rate.
// - Six-bit count readable, upper bits zero, writes ignored.
// - Count latched when chip select falls.
// - Counter resets to mid-range 10 0000.
// - First channel count has fixed ID bit two.
// - Filtered overcurrent latches shutdown until frame end.
// - Overcurrent ORed into CRC fault flag.
// - Thermal fault disables channel until rewritten enable.
// - Reset restores defaults, clears FIFOs, tri-states bus.
// - Control-register writes abort, other accesses never.
// - Abort leaves enable and thermal register alone.
// - Abort starts at address, idles bus, holds; code leaves bus drive to enable and overcurrent only.
// - After abort write clear FIFOs, then enforce gap.
// - Changed gap setting restarts delay with new value.
// - Spread bits vary, frame interval stays constant.
// - Offset writes refused while loop update frozen.
`ifndef SS_ABORT_REGS_SVH
`define SS_ABORT_REGS_SVH

// Register addresses seen on the serial port (seven-bit address field).
`define ADDR_W 7
`define A_CHANNEL_CONTROL 7'h00
`define A_CRC_POLYNOMIAL 7'h01
`define A_CRC_START_VALUE 7'h02
`define A_WORD_CRC_LENGTH 7'h03
`define A_SPREAD_CONTROL 7'h04
`define A_LOOP_OFFSET_HIGH 7'h05
`define A_LOOP_OFFSET_LOW 7'h06
`define A_LOOP_UPDOWN_COUNT 7'h07
`define A_CHANNEL_ON_THERMAL 7'h10
`define A_CHANNEL_STATUS 7'h11
`define A_CHAN_STRIDE 7'h08

// Spread control fields.
`define F_SWING_LSB 0
`define F_SEQLEN_LSB 2
`define F_FREEZE 4
`define F_SPREAD_ON 5
`define SPREAD_WMASK 8'h3f

// Reset values.
`define R_SPREAD 8'h00
`define R_OFFSET 9'h000
`define R_COUNT 6'h20
`define F_ID_BIT 2

// Timing counts.
`define FAST_ACQ_CYCLES 7'h40
`define THERM_MIN_CYCLES 5'h10
`define GAP_UNIT_CYCLES 8'h28
`define OC_FILTER_CYCLES 4'hf

`endif

// *** logic/ss_abort_pkg.sv ***
/*
 Types shared by the spread-spectrum and abort block.
 Assumes nothing of its surroundings.
*/
package ss_abort_pkg;
   // Serial frame states, Gray along the usual path.
   typedef enum logic [1:0] {
      SP_IDLE = 2'b00,
      SP_ADDR = 2'b01,
      SP_DATA = 2'b11
   } spi_state_e;
   // Link sequencer states.
   typedef enum logic [1:0] {
      LK_IDLE = 2'b00,
      LK_GAP = 2'b01,
      LK_RUN = 2'b11,
      LK_ABORT = 2'b10
   } link_state_e;
endpackage

// *** logic/seq_gen.sv ***
/*
 Pseudo-random sequence register with selectable length and feedback taps.
 Assumes a step pulse once per transmitted bit period on the same clock.
*/
`timescale 1ns/1ps
`include "ss_abort_regs.svh"
module seq_gen #(
   parameter int W = 15
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Control.
   input wire logic step,
   input wire logic [1:0] len_sel,
   // Output.
   output logic seq_bit
);
   logic [W-1:0] sr_reg;
   logic fb;

   ////////////////////////////////////////////////////////////////////////
   // Tap choice per length code.
   always_comb begin
      unique case (len_sel)
         2'b00: fb = sr_reg[5] ^ sr_reg[4];
         2'b01: fb = sr_reg[6] ^ sr_reg[5];
         2'b10: fb = sr_reg[10] ^ sr_reg[8];
         2'b11: fb = sr_reg[14] ^ sr_reg[13];
      endcase
   end

   // Shift once per bit; a lock-up at zero is forced out by reseeding.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sr_reg <= {{(W-1){1'b0}}, 1'b1};
      end else if (sr_reg == '0) begin
         sr_reg <= {{(W-1){1'b0}}, 1'b1};
      end else if (step) begin
         sr_reg <= {sr_reg[W-2:0], fb};
      end
   end

   // Output the low stage so every length shares one tap point.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         seq_bit <= 1'b0;
      end else begin
         seq_bit <= sr_reg[0];
      end
   end

   a_never_zero: assert property (@(posedge clk) disable iff (!rst_n)
      sr_reg != '0)
      else $error("sequence register stuck at zero");
endmodule

// *** logic/spread_spectrum_abort_ctrl.sv ***
/*
 Per-channel spread-spectrum, protection and abort control behind a serial
 register port. Assumes a 40 MHz clk, synchronous rst_n, serial pins and
 analog detector inputs coming from outside the clock domain.
*/
`timescale 1ns/1ps
`include "ss_abort_regs.svh"
module spread_spectrum_abort_ctrl #(
   parameter int CHAN = 0,
   parameter logic [7:0] GAP_UNITS = 8'h04,
   parameter logic [1:0] ID_VALUE = 2'b10 // Arbitrary identification value.
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Serial register port.
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   // Analog detectors and bit timing.
   input wire logic oc_source,
   input wire logic oc_sink,
   input wire logic therm_hot,
   input wire logic frame_end,
   input wire logic bit_tick,
   input wire logic loop_up,
   // Bus drive.
   output logic bus_high_line_o,
   output logic bus_high_line_oe_n,
   output logic bus_low_line_o,
   output logic bus_low_line_oe_n,
   // Status and controls to the rest of the channel.
   output logic abort_o,
   output logic fifo_clear,
   output logic gap_busy,
   output logic fast_acq,
   output logic deviate_o,
   output logic spread_bit,
   output logic [8:0] center_trim,
   output logic crc_fault_flag
);
   logic [1:0] cs_s, sck_s, mo_s;
   logic [1:0] ocs_s, ock_s, th_s;
   logic sck_d, cs_d;
   ss_abort_pkg::spi_state_e sp_reg;
   logic [3:0] bcnt_reg;
   logic wr_reg;
   logic [`ADDR_W-1:0] addr_reg;
   logic [7:0] sh_reg, rd_reg;
   logic [7:0] spread_control_reg;
   logic [8:0] trim_reg;
   logic [5:0] loop_counter_value, cnt_snap_reg;
   logic [6:0] acq_reg;
   logic [1:0] channel_on_bit, thermal_flag;
   logic [4:0] th_cnt;
   logic oc_filt_reg;
   logic [3:0] oc_cnt;
   logic oc_latch;
   logic [7:0] gap_reg;
   logic [7:0] gap_cnt;
   logic [7:0] unit_cnt;
   logic seq_raw;
   ss_abort_pkg::link_state_e lk_reg;
   logic sck_rise, cs_fall, cs_rise, ctrl_hit, abort_act, off_wr, ctrl_done;
   logic [`ADDR_W-1:0] loc;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the first stage feeds only the second.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cs_s <= 2'b11;
         sck_s <= 2'b00;
         mo_s <= 2'b00;
         ocs_s <= 2'b00;
         ock_s <= 2'b00;
         th_s <= 2'b00;
         sck_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         cs_s <= {cs_s[0], cs_n};
         sck_s <= {sck_s[0], sclk};
         mo_s <= {mo_s[0], mosi};
         ocs_s <= {ocs_s[0], oc_source};
         ock_s <= {ock_s[0], oc_sink};
         th_s <= {th_s[0], therm_hot};
         sck_d <= sck_s[1];
         cs_d <= cs_s[1];
      end
   end
   assign sck_rise = sck_s[1] & ~sck_d & ~cs_s[1];
   assign cs_fall = cs_d & ~cs_s[1];
   assign cs_rise = ~cs_d & cs_s[1];
   assign loc = addr_reg - `A_CHAN_STRIDE * 7'(CHAN);
   assign ctrl_hit = wr_reg && (loc == `A_CHANNEL_CONTROL || loc == `A_CRC_POLYNOMIAL
      || loc == `A_CRC_START_VALUE || loc == `A_WORD_CRC_LENGTH
      || loc == `A_SPREAD_CONTROL);

   ////////////////////////////////////////////////////////////////////////
   // Serial frame: write bit, seven address bits, eight data bits.
   always_ff @(posedge clk) begin
      if (!rst_n || cs_s[1]) begin
         sp_reg <= ss_abort_pkg::SP_IDLE;
         bcnt_reg <= 4'h0;
         wr_reg <= 1'b0;
         addr_reg <= '0;
         sh_reg <= 8'h00;
      end else if (sck_rise) begin
         bcnt_reg <= bcnt_reg + 4'h1;
         sh_reg <= {sh_reg[6:0], mo_s[1]};
         unique case (sp_reg)
            ss_abort_pkg::SP_IDLE: begin
               wr_reg <= mo_s[1];
               sp_reg <= ss_abort_pkg::SP_ADDR;
            end
            ss_abort_pkg::SP_ADDR: begin
               addr_reg <= {addr_reg[5:0], mo_s[1]};
               if (bcnt_reg == 4'h7) begin
                  sp_reg <= ss_abort_pkg::SP_DATA;
                  bcnt_reg <= 4'h0;
               end
            end
            ss_abort_pkg::SP_DATA: ;
         endcase
      end
   end
   // A write is complete when eight data bits arrived before the deselect.
   assign ctrl_done = cs_rise && sp_reg == ss_abort_pkg::SP_DATA && bcnt_reg == 4'h8
      && ctrl_hit;
   assign off_wr = cs_rise && sp_reg == ss_abort_pkg::SP_DATA && bcnt_reg == 4'h8
      && wr_reg && !spread_control_reg[`F_FREEZE]
      && (loc == `A_LOOP_OFFSET_HIGH || loc == `A_LOOP_OFFSET_LOW);
   // Abort is held from the address onward until the deselect.
   assign abort_act = sp_reg == ss_abort_pkg::SP_DATA && ctrl_hit && !cs_s[1];

   ////////////////////////////////////////////////////////////////////////
   // Register writes; reset restores defaults.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         spread_control_reg <= `R_SPREAD;
         trim_reg <= `R_OFFSET;
         gap_reg <= GAP_UNITS;
      end else if (cs_rise && sp_reg == ss_abort_pkg::SP_DATA && bcnt_reg == 4'h8 && wr_reg) begin
         if (loc == `A_SPREAD_CONTROL) begin
            spread_control_reg <= sh_reg & `SPREAD_WMASK;
         end
         if (loc == `A_CHANNEL_CONTROL) begin
            gap_reg <= sh_reg;
         end
         if (off_wr && loc == `A_LOOP_OFFSET_HIGH) begin
            trim_reg[8] <= sh_reg[0];
         end
         if (off_wr && loc == `A_LOOP_OFFSET_LOW) begin
            trim_reg[7:0] <= sh_reg;
         end
      end
   end

   // Channel enable and thermal flags; an abort never touches these.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         channel_on_bit <= 2'b00;
         thermal_flag <= 2'b00;
         th_cnt <= 5'h00;
      end else begin
         th_cnt <= th_s[1] ? (th_cnt == `THERM_MIN_CYCLES ? th_cnt : th_cnt + 5'h01) : 5'h00;
         if (th_cnt == `THERM_MIN_CYCLES) begin
            thermal_flag[CHAN] <= 1'b1;
            channel_on_bit[CHAN] <= 1'b0;
         end else if (cs_rise && sp_reg == ss_abort_pkg::SP_DATA && bcnt_reg == 4'h8
                      && wr_reg && addr_reg == `A_CHANNEL_ON_THERMAL) begin
            channel_on_bit[CHAN] <= sh_reg[CHAN] & ~th_s[1];
         end else if (cs_rise && !wr_reg && addr_reg == `A_CHANNEL_ON_THERMAL && !th_s[1]) begin
            thermal_flag[CHAN] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Acquisition timer and loop up/down counter.
   always_ff @(posedge clk) begin
      if (!rst_n || off_wr) begin
         acq_reg <= `FAST_ACQ_CYCLES;
      end else if (bit_tick && acq_reg != 7'h00) begin
         acq_reg <= acq_reg - 7'h01;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         loop_counter_value <= `R_COUNT;
      end else if (bit_tick && !spread_control_reg[`F_FREEZE]) begin
         if (loop_up && loop_counter_value != 6'h3f) begin
            loop_counter_value <= loop_counter_value + 6'h01;
         end else if (!loop_up && loop_counter_value != 6'h00) begin
            loop_counter_value <= loop_counter_value - 6'h01;
         end
      end
   end
   // Snapshot so the value cannot move under a read in progress.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_snap_reg <= `R_COUNT;
      end else if (cs_fall) begin
         cnt_snap_reg <= loop_counter_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data; the count register ignores writes.
   always_comb begin
      rd_reg = 8'h00;
      unique case (loc)
         `A_SPREAD_CONTROL: rd_reg = spread_control_reg;
         `A_LOOP_OFFSET_HIGH: rd_reg = {7'h00, trim_reg[8]};
         `A_LOOP_OFFSET_LOW: rd_reg = trim_reg[7:0];
         `A_LOOP_UPDOWN_COUNT: begin
            rd_reg = {2'b00, cnt_snap_reg};
            if (CHAN == 0) begin
               rd_reg[`F_ID_BIT] = ID_VALUE[0];
            end
         end
         default: rd_reg = 8'h00;
      endcase
      if (addr_reg == `A_CHANNEL_ON_THERMAL) begin
         rd_reg = {thermal_flag[1], thermal_flag[0], 4'h0, channel_on_bit};
      end
      if (addr_reg == `A_CHANNEL_STATUS) begin
         rd_reg = {7'h00, crc_fault_flag};
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n || cs_s[1]) begin
         miso <= 1'b0;
      end else if (sp_reg == ss_abort_pkg::SP_DATA && sck_rise && bcnt_reg < 4'h8) begin
         miso <= rd_reg[3'(4'h7 - bcnt_reg)];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Overcurrent filter and latch, cleared at frame end.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         oc_cnt <= 4'h0;
         oc_latch <= 1'b0;
         oc_filt_reg <= 1'b0;
      end else begin
         oc_filt_reg <= ocs_s[1] | ock_s[1];
         oc_cnt <= oc_filt_reg ? (oc_cnt == `OC_FILTER_CYCLES ? oc_cnt : oc_cnt + 4'h1) : 4'h0;
         if (oc_cnt == `OC_FILTER_CYCLES) begin
            oc_latch <= 1'b1;
         end else if (frame_end) begin
            oc_latch <= 1'b0;
         end
      end
   end
   // The raw OR is visible as a CRC fault.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         crc_fault_flag <= 1'b0;
      end else if (oc_filt_reg) begin
         crc_fault_flag <= 1'b1;
      end else if (cs_rise && !wr_reg && addr_reg == `A_CHANNEL_STATUS) begin
         crc_fault_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link sequencer: abort, FIFO clear, gap timed from the new setting.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lk_reg <= ss_abort_pkg::LK_IDLE;
         gap_cnt <= 8'h00;
         unit_cnt <= 8'h00;
         fifo_clear <= 1'b1;
      end else begin
         fifo_clear <= 1'b0;
         unique case (lk_reg)
            ss_abort_pkg::LK_IDLE: if (channel_on_bit[CHAN]) lk_reg <= ss_abort_pkg::LK_RUN;
            ss_abort_pkg::LK_RUN: if (!channel_on_bit[CHAN]) lk_reg <= ss_abort_pkg::LK_IDLE;
            ss_abort_pkg::LK_ABORT: if (ctrl_done) begin
               fifo_clear <= 1'b1;
               gap_cnt <= (loc == `A_CHANNEL_CONTROL) ? sh_reg : gap_reg;
               unit_cnt <= `GAP_UNIT_CYCLES;
               lk_reg <= ss_abort_pkg::LK_GAP;
            end else if (cs_s[1]) begin
               lk_reg <= ss_abort_pkg::LK_GAP;
               gap_cnt <= gap_reg;
            end
            ss_abort_pkg::LK_GAP: begin
               unit_cnt <= unit_cnt == 8'h00 ? `GAP_UNIT_CYCLES : unit_cnt - 8'h01;
               if (gap_cnt == 8'h00) lk_reg <= ss_abort_pkg::LK_RUN;
               else if (unit_cnt == 8'h00) gap_cnt <= gap_cnt - 8'h01;
            end
         endcase
         if (abort_act) begin
            lk_reg <= ss_abort_pkg::LK_ABORT;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drive and status outputs, all registered.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bus_high_line_o <= 1'b0;
         bus_low_line_o <= 1'b0;
         bus_high_line_oe_n <= 1'b1;
         bus_low_line_oe_n <= 1'b1;
         abort_o <= 1'b0;
         gap_busy <= 1'b0;
         fast_acq <= 1'b1;
         deviate_o <= 1'b0;
         spread_bit <= 1'b0;
         center_trim <= `R_OFFSET;
      end else begin
         bus_high_line_o <= 1'b1;
         bus_low_line_o <= 1'b0;
         // Off, thermal or overcurrent float the bus.
         bus_high_line_oe_n <= ~channel_on_bit[CHAN] | oc_latch;
         bus_low_line_oe_n <= ~channel_on_bit[CHAN] | oc_latch;
         abort_o <= abort_act;
         gap_busy <= lk_reg == ss_abort_pkg::LK_GAP;
         fast_acq <= acq_reg != 7'h00 || off_wr;
         // Only code 10 spreads; 11 leaves the trimmed rate fixed.
         deviate_o <= spread_control_reg[`F_SPREAD_ON]
            && spread_control_reg[`F_SWING_LSB +: 2] == 2'b10;
         spread_bit <= seq_raw & spread_control_reg[`F_SPREAD_ON]
            & (spread_control_reg[`F_SWING_LSB +: 2] == 2'b10);
         center_trim <= trim_reg;
      end
   end

   seq_gen #(.W(15)) u_seq (
      .clk(clk),
      .rst_n(rst_n),
      .step(bit_tick),
      .len_sel(spread_control_reg[`F_SEQLEN_LSB +: 2]),
      .seq_bit(seq_raw)
   );

   a_abort_holds: assert property (@(posedge clk) disable iff (!rst_n)
      abort_act |=> abort_o) else $error("abort not shown");
   a_oc_floats: assert property (@(posedge clk) disable iff (!rst_n)
      oc_latch |=> bus_high_line_oe_n) else $error("bus driven in overcurrent");
   a_snap_steady: assert property (@(posedge clk) disable iff (!rst_n)
      !cs_s[1] && !cs_fall |=> $stable(cnt_snap_reg)) else $error("count moved");
   a_fault_flag: assert property (@(posedge clk) disable iff (!rst_n)
      oc_filt_reg |=> crc_fault_flag) else $error("fault not flagged");
   a_freeze_trim: assert property (@(posedge clk) disable iff (!rst_n)
      spread_control_reg[`F_FREEZE] && $stable(spread_control_reg) |=> $stable(trim_reg))
      else $error("trim changed while frozen");
   a_swing_off: assert property (@(posedge clk) disable iff (!rst_n)
      spread_control_reg[`F_SWING_LSB +: 2] == 2'b11 |=> !deviate_o)
      else $error("deviation on");
   a_fifo_clear: assert property (@(posedge clk) disable iff (!rst_n)
      lk_reg == ss_abort_pkg::LK_ABORT && ctrl_done |=> fifo_clear && gap_busy == 1'b0
      ##1 gap_busy) else $error("no clear then gap");
   a_therm_off: assert property (@(posedge clk) disable iff (!rst_n)
      th_cnt == `THERM_MIN_CYCLES |=> !channel_on_bit[CHAN]) else $error("hot channel on");
endmodule

// *** tb/bus_node_model.sv ***
/*
 Behavioural remote bus nodes and analog detectors for one channel.
 Assumes the bench clock and commands that change off the falling edge.
*/
`timescale 1ns/1ps
module bus_node_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Commands from the bench.
   input wire logic run,
   input wire logic [1:0] short_cmd,
   input wire logic hot_cmd,
   // Timing and detector outputs.
   output logic bit_tick,
   output logic frame_end,
   output logic loop_up,
   output logic oc_source,
   output logic oc_sink,
   output logic therm_hot
);
   logic [1:0] div_reg;
   logic [3:0] bit_reg;
   logic [4:0] lfsr_reg;
   ////////////////////////////////////////////////////////////////////////////////
   // Bit periods of four clocks; the nodes stay silent while not running.
   always_ff @(posedge clk) begin
      if (!rst_n || !run) begin
         div_reg <= 2'b00;
         bit_reg <= 4'h0;
      end else begin
         div_reg <= div_reg + 2'b01;
         if (div_reg == 2'b11) bit_reg <= bit_reg + 4'h1;
      end
   end
   // Phase error wanders so the loop counter really moves both ways.
   always_ff @(posedge clk) begin
      if (!rst_n) lfsr_reg <= 5'h01;
      else if (div_reg == 2'b11) lfsr_reg <= {lfsr_reg[3:0], lfsr_reg[4] ^ lfsr_reg[2]};
   end
   // Combinational so that every output is defined from time zero.
   assign bit_tick = run & rst_n & (div_reg == 2'b11);
   assign frame_end = bit_tick & (bit_reg == 4'hf);
   assign loop_up = rst_n & lfsr_reg[0];
   assign oc_source = short_cmd[0];
   assign oc_sink = short_cmd[1];
   assign therm_hot = hot_cmd;
endmodule

// *** tb/test_spread_spectrum_abort_ctrl.sv ***
/*
 Self-checking bench for the spread-spectrum and abort block, channel zero.
 Assumes the design files and the bus node model are compiled first.
*/
`timescale 1ns/1ps
module test_spread_spectrum_abort_ctrl;
   localparam logic [1:0] ID_VALUE = 2'b10; // Arbitrary identification value.
   logic clk, rst_n, cs_n, sclk, mosi, miso, run, hot_cmd, rd_tog;
   logic [1:0] short_cmd;
   logic oc_source, oc_sink, therm_hot, frame_end, bit_tick, loop_up;
   logic hi_o, hi_oe_n, lo_o, lo_oe_n, abort_o, fifo_clear, gap_busy;
   logic fast_acq, deviate_o, spread_bit, crc_fault_flag, abort_seen, clear_seen;
   logic [8:0] center_trim;
   logic [7:0] rd_val, lo, id_exp;
   logic [7:0] exp_q[$];
   int err_total, compares, gap_cnt, ticks, ones;
   ////////////////////////////////////////////////////////////////////////////////
   spread_spectrum_abort_ctrl #(.CHAN(0), .GAP_UNITS(8'h04), .ID_VALUE(ID_VALUE))
   spread_spectrum_abort_ctrl_i (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
      .mosi(mosi), .miso(miso), .oc_source(oc_source), .oc_sink(oc_sink),
      .therm_hot(therm_hot), .frame_end(frame_end), .bit_tick(bit_tick), .loop_up(loop_up),
      .bus_high_line_o(hi_o), .bus_high_line_oe_n(hi_oe_n), .bus_low_line_o(lo_o),
      .bus_low_line_oe_n(lo_oe_n), .abort_o(abort_o), .fifo_clear(fifo_clear),
      .gap_busy(gap_busy), .fast_acq(fast_acq), .deviate_o(deviate_o),
      .spread_bit(spread_bit), .center_trim(center_trim), .crc_fault_flag(crc_fault_flag));
   bus_node_model bus_node_model_i (.clk(clk), .rst_n(rst_n), .run(run),
      .short_cmd(short_cmd), .hot_cmd(hot_cmd), .bit_tick(bit_tick), .frame_end(frame_end),
      .loop_up(loop_up), .oc_source(oc_source), .oc_sink(oc_sink), .therm_hot(therm_hot));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock of 25 ns.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Flags what the block shows on every rising edge; the bench clears them off-edge.
   always @(posedge clk) begin
      if (abort_o === 1'b1) abort_seen <= 1'b1;
      if (fifo_clear === 1'b1) clear_seen <= 1'b1;
      if (gap_busy === 1'b1) gap_cnt <= gap_cnt + 1;
      if (bit_tick === 1'b1) ticks <= ticks + 1;
      if (bit_tick === 1'b1 && spread_bit === 1'b1) ones <= ones + 1;
   end
   // Each finished read is compared with the oldest note on the queue.
   always @(rd_tog) begin
      if (exp_q.size() != 0) check(rd_val, exp_q.pop_front());
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic tmo();
      err_total++;
      $display("BAD t=%0t wait ran out", $time);
      summarize();
   endtask
   // Whole 16-bit frame, four clocks a half period so the synchronisers keep up.
   task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
      logic [15:0] f;
      f = {w, a, d};
      cs_n = 1'b0;
      cyc(4);
      for (int i = 15; i >= 0; i--) begin
         mosi = f[i];
         cyc(4);
         sclk = 1'b1;
         cyc(4);
         if (i < 8) rd_val[i] = miso;
         sclk = 1'b0;
      end
      cyc(4);
      cs_n = 1'b1;
      cyc(6);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 8'h00);
      rd_tog = ~rd_tog;
   endtask
   task automatic wait_ticks(input int t);
      int n;
      for (n = 0; n < 1000 && ticks < t; n++) cyc(1);
      if (n >= 1000) tmo();
   endtask
   task automatic wait_gap();
      int n;
      for (n = 0; n < 12000 && gap_busy !== 1'b0; n++) cyc(1);
      if (n >= 12000) tmo();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      {rst_n, sclk, mosi, run, hot_cmd, rd_tog, short_cmd} = 8'h00;
      cs_n = 1'b1;
      {err_total, compares, gap_cnt, ticks, ones} = '0;
      void'($urandom(3));
      id_exp = {2'b00, 6'h20} | {5'h00, ID_VALUE[0], 2'b00};
      cyc(2);
      check({hi_oe_n, lo_oe_n, fifo_clear, fast_acq}, 4'hf);
      rst_n = 1'b1;
      cyc(4);
      check(center_trim, 9'h000);
      check({hi_o, lo_o, hi_oe_n}, 3'b101);
      rd(7'h07, id_exp);
      rd(7'h05, 8'h00);
      rd(7'h06, 8'h00);
      xfer(1'b1, 7'h07, 8'hff);
      rd(7'h07, id_exp);
      $display("reset test done");
      lo = 8'($urandom);
      xfer(1'b1, 7'h05, 8'h01); // freeze bit is still clear
      xfer(1'b1, 7'h06, lo);
      check(center_trim, {1'b1, lo});
      rd(7'h06, lo);
      check(fast_acq, 1'b1);
      ticks = 0;
      run = 1'b1;
      wait_ticks(62);
      check(fast_acq, 1'b1);
      wait_ticks(67);
      check(fast_acq, 1'b0);
      run = 1'b0;
      xfer(1'b1, 7'h04, 8'h10);
      xfer(1'b1, 7'h06, ~lo);
      check(center_trim, {1'b1, lo});
      rd(7'h06, lo);
      $display("offset test done");
      // Every length code must keep the sequence moving, never stuck.
      for (int s = 0; s < 4; s++) begin
         xfer(1'b1, 7'h04, 8'h22 | 8'(s << 2)); // swing 10 while spreading
         check(deviate_o, 1'b1);
         {ticks, ones} = '0;
         run = 1'b1;
         wait_ticks(40);
         run = 1'b0;
         check(ones > 0 && ones < ticks, 1'b1);
      end
      xfer(1'b1, 7'h04, 8'h23); // swing 11
      check(deviate_o, 1'b0);
      rd(7'h04, 8'h23);
      $display("spread test done");
      xfer(1'b1, 7'h10, 8'h01);
      for (int a = 0; a < 7; a++) begin
         wait_gap();
         {abort_seen, clear_seen} = 2'b00;
         xfer(1'b1, 7'(a), 8'h01);
         check({abort_seen, clear_seen}, {2{a < 5}});
      end
      abort_seen = 1'b0;
      rd(7'h10, 8'h01);
      check(abort_seen, 1'b0);
      xfer(1'b1, 7'h00, 8'h06);
      cyc(30);
      xfer(1'b1, 7'h00, 8'h01);
      gap_cnt = 0;
      wait_gap();
      check(gap_cnt inside {[30:41]}, 1'b1);
      $display("abort test done");
      for (int k = 1; k < 3; k++) begin
         short_cmd = 2'(k);
         cyc(30);
         check({hi_oe_n, lo_oe_n, crc_fault_flag}, 3'b111);
         short_cmd = 2'b00;
         rd(7'h11, 8'h01);
         check(crc_fault_flag, 1'b0);
         run = 1'b1;
         cyc(70);
         run = 1'b0;
         check(hi_oe_n, 1'b0);
      end
      hot_cmd = 1'b1;
      cyc(30);
      check({hi_oe_n, lo_oe_n}, 2'b11);
      hot_cmd = 1'b0;
      cyc(4);
      rd(7'h10, 8'h40);
      rd(7'h10, 8'h00);
      xfer(1'b1, 7'h10, 8'h01); // re-enable only after cooling
      rd(7'h10, 8'h01);
      $display("protection test done");
      cyc(4);
      summarize();
   end
endmodule
